// file: src/rdmc_channel.sv
/*
 * One channel's mode machine, termination selection and receiver-detect
 * interval timer.
 * Assumes signal_active and load_found are synchronous to clk, and that
 * load_found is valid in the cycle that detect_strobe is high.
 */
`timescale 1ns/100ps
`default_nettype none

module rdmc_channel #(
  parameter int INTERVAL_CYC = rdmc_pkg::RX_DETECT_INTERVAL_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic pair_enable,
  input wire logic signal_active,
  input wire logic load_found,
  output logic [1:0] mode,
  output logic detect_strobe,
  output logic [1:0] in_term,
  output logic [1:0] out_term,
  output logic detector_on
);

  // ---------------------------------------------------------------------
  // Mode machine
  // ---------------------------------------------------------------------
  rdmc_pkg::rdmc_mode_e mode_q, mode_d;
  logic [rdmc_pkg::DETECT_COUNT_W-1:0] timer_q, timer_d;
  logic strobe_q, strobe_d;
  logic [1:0] in_term_q, in_term_d, out_term_q, out_term_d;
  logic det_on_q, det_on_d;

  localparam logic [rdmc_pkg::DETECT_COUNT_W-1:0] TIMER_LAST =
    rdmc_pkg::DETECT_COUNT_W'(INTERVAL_CYC - 1);

  always_comb begin
    mode_d = mode_q;
    timer_d = timer_q;
    strobe_d = 1'b0;
    if (!pair_enable) begin
      mode_d = rdmc_pkg::RDMC_POWER_DOWN;
      timer_d = '0;
    end else begin
      case (mode_q)
        rdmc_pkg::RDMC_POWER_DOWN: begin
          // Leaving power-down goes through slumber; a load is probed there unless signal_active wakes the channel first.
          mode_d = rdmc_pkg::RDMC_SLUMBER;
          timer_d = '0;
        end
        rdmc_pkg::RDMC_ACTIVE: begin
          if (!signal_active) begin
            mode_d = rdmc_pkg::RDMC_SLUMBER;
            timer_d = '0;
          end
        end
        rdmc_pkg::RDMC_SLUMBER, rdmc_pkg::RDMC_UNPLUG: begin
          // The probe result is read in the same cycle that the strobe is out.
          timer_d = (timer_q == TIMER_LAST) ? '0 : timer_q + 1'b1;
          strobe_d = (timer_q == TIMER_LAST);
          if (mode_q == rdmc_pkg::RDMC_SLUMBER && signal_active) begin
            mode_d = rdmc_pkg::RDMC_ACTIVE;
            strobe_d = 1'b0;
          end else if (strobe_q) begin
            if (!load_found) begin
              mode_d = rdmc_pkg::RDMC_UNPLUG;
            end else begin
              mode_d = rdmc_pkg::RDMC_SLUMBER;
            end
          end
        end
        default: begin
          mode_d = rdmc_pkg::RDMC_POWER_DOWN;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------------
  // Termination and detector enable follow the next mode
  // ---------------------------------------------------------------------
  always_comb begin
    det_on_d = 1'b0;
    case (mode_d)
      rdmc_pkg::RDMC_POWER_DOWN: begin
        in_term_d = rdmc_pkg::IN_TERM_WEAK_GND;
        out_term_d = rdmc_pkg::OUT_TERM_HIGHZ;
      end
      rdmc_pkg::RDMC_UNPLUG: begin
        in_term_d = rdmc_pkg::IN_TERM_HIGHZ;
        out_term_d = rdmc_pkg::OUT_TERM_WEAK_VDD;
      end
      rdmc_pkg::RDMC_SLUMBER: begin
        in_term_d = rdmc_pkg::IN_TERM_50_OHM;
        out_term_d = rdmc_pkg::OUT_TERM_WEAK_VDD;
        det_on_d = 1'b1;
      end
      rdmc_pkg::RDMC_ACTIVE: begin
        in_term_d = rdmc_pkg::IN_TERM_50_OHM;
        out_term_d = rdmc_pkg::OUT_TERM_50_OHM;
        det_on_d = 1'b1;
      end
      default: begin
        in_term_d = rdmc_pkg::IN_TERM_WEAK_GND;
        out_term_d = rdmc_pkg::OUT_TERM_HIGHZ;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mode_q <= rdmc_pkg::RDMC_POWER_DOWN;
      timer_q <= '0;
      strobe_q <= 1'b0;
      in_term_q <= rdmc_pkg::IN_TERM_WEAK_GND;
      out_term_q <= rdmc_pkg::OUT_TERM_HIGHZ;
      det_on_q <= 1'b0;
    end else begin
      mode_q <= mode_d;
      timer_q <= timer_d;
      strobe_q <= strobe_d;
      in_term_q <= in_term_d;
      out_term_q <= out_term_d;
      det_on_q <= det_on_d;
    end
  end

  assign mode = mode_q;
  assign detect_strobe = strobe_q;
  assign in_term = in_term_q;
  assign out_term = out_term_q;
  assign detector_on = det_on_q;

endmodule : rdmc_channel

`default_nettype wire

// file: src/rdmc_pkg.sv
/*
 * Shared constants for the redriver channel mode control: mode encoding,
 * strap level codes, equalizer and flat-gain selection codes, termination
 * codes and receiver-detect timing.
 * Assumes the strap pins arrive already resolved into two-bit level codes.
 */
package rdmc_pkg;

  // ---------------------------------------------------------------------
  // Channel modes
  // ---------------------------------------------------------------------
  typedef enum logic [1:0] {
    RDMC_POWER_DOWN,
    RDMC_UNPLUG,
    RDMC_SLUMBER,
    RDMC_ACTIVE
  } rdmc_mode_e;

  // ---------------------------------------------------------------------
  // Four-level strap codes as seen on the pins
  // ---------------------------------------------------------------------
  localparam logic [1:0] STRAP_LOW = 2'h0;
  localparam logic [1:0] STRAP_RES = 2'h1;
  localparam logic [1:0] STRAP_OPEN = 2'h2;
  localparam logic [1:0] STRAP_HIGH = 2'h3;

  // ---------------------------------------------------------------------
  // Equalizer boost codes at the upper frequency
  // ---------------------------------------------------------------------
  localparam logic [1:0] EQ_6P7_DB = 2'h0;
  localparam logic [1:0] EQ_8P9_DB = 2'h1;
  localparam logic [1:0] EQ_10P9_DB = 2'h2;
  localparam logic [1:0] EQ_13P1_DB = 2'h3;
  localparam logic [1:0] EQ_RESET = EQ_8P9_DB;

  // ---------------------------------------------------------------------
  // Flat-gain codes
  // ---------------------------------------------------------------------
  localparam logic [1:0] FG_M3P0_DB = 2'h0;
  localparam logic [1:0] FG_M1P5_DB = 2'h1;
  localparam logic [1:0] FG_0P0_DB = 2'h2;
  localparam logic [1:0] FG_P2P0_DB = 2'h3;
  localparam logic [1:0] FG_RESET = FG_0P0_DB;

  // ---------------------------------------------------------------------
  // Termination codes
  // ---------------------------------------------------------------------
  localparam logic [1:0] IN_TERM_HIGHZ = 2'h0;
  localparam logic [1:0] IN_TERM_WEAK_GND = 2'h1;
  localparam logic [1:0] IN_TERM_50_OHM = 2'h2;
  localparam logic [1:0] OUT_TERM_HIGHZ = 2'h0;
  localparam logic [1:0] OUT_TERM_WEAK_VDD = 2'h1;
  localparam logic [1:0] OUT_TERM_50_OHM = 2'h2;

  // ---------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 4000;
  localparam int RX_DETECT_INTERVAL_MS = 6;
  // Scaled through nanoseconds: six milliseconds counted in picoseconds
  // would overflow a 32-bit int and shorten the probe interval.
  localparam int RX_DETECT_INTERVAL_CYC =
    (RX_DETECT_INTERVAL_MS * 1000000) / (CLK_PERIOD_PS / 1000);
  localparam int DETECT_COUNT_W = 21;

endpackage : rdmc_pkg

// file: src/rdmc_top.sv
/*
 * Four-channel mode and configuration control for a linear redriver:
 * per-channel mode machines, pair enables and strap decoding.
 * Assumes all inputs are synchronous to clk; strap pins arrive as two-bit
 * level codes from the analog four-level comparators.
 */
// Summary of operation
// - Idle input moves active channel to slumber.
// - Slumber decided per channel, independently.
// - Signal detector keeps running during slumber.
// - Slumber probes load; none found means unplug.
// - Load found returns to slumber; probe every 6ms.
// - Termination set by mode for input and output.
// - Equalizer strap decodes to four boost levels.
// - Flat-gain strap decodes to four gain levels.
// - Pair enable low forces power-down; high runs.
`timescale 1ns/100ps
`default_nettype none

module rdmc_top #(
  parameter int NUM_CH = 4,
  parameter int INTERVAL_CYC = rdmc_pkg::RX_DETECT_INTERVAL_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic first_pair_enable,
  input wire logic second_pair_enable,
  input wire logic [NUM_CH-1:0] signal_active,
  input wire logic [NUM_CH-1:0] load_found,
  input wire logic [1:0] equalizer_select_ch0,
  input wire logic [1:0] equalizer_select_ch1,
  input wire logic [1:0] equalizer_select_ch2,
  input wire logic [1:0] equalizer_select_ch3,
  input wire logic [1:0] flat_gain_select_ch0,
  input wire logic [1:0] flat_gain_select_ch1,
  input wire logic [1:0] flat_gain_select_ch2,
  input wire logic [1:0] flat_gain_select_ch3,
  output logic [2*NUM_CH-1:0] channel_mode,
  output logic [NUM_CH-1:0] power_down_mode,
  output logic [NUM_CH-1:0] detect_strobe,
  output logic [NUM_CH-1:0] detector_on,
  output logic [2*NUM_CH-1:0] in_term,
  output logic [2*NUM_CH-1:0] out_term,
  output logic [2*NUM_CH-1:0] eq_boost,
  output logic [2*NUM_CH-1:0] flat_gain
);

  // ---------------------------------------------------------------------
  // Strap decoders
  // ---------------------------------------------------------------------
  function automatic logic [1:0] eq_decode(input logic [1:0] strap);
    case (strap)
      rdmc_pkg::STRAP_LOW: eq_decode = rdmc_pkg::EQ_10P9_DB;
      rdmc_pkg::STRAP_RES: eq_decode = rdmc_pkg::EQ_6P7_DB;
      rdmc_pkg::STRAP_HIGH: eq_decode = rdmc_pkg::EQ_13P1_DB;
      default: eq_decode = rdmc_pkg::EQ_8P9_DB;
    endcase
  endfunction : eq_decode

  function automatic logic [1:0] fg_decode(input logic [1:0] strap);
    case (strap)
      rdmc_pkg::STRAP_LOW: fg_decode = rdmc_pkg::FG_M3P0_DB;
      rdmc_pkg::STRAP_RES: fg_decode = rdmc_pkg::FG_M1P5_DB;
      rdmc_pkg::STRAP_HIGH: fg_decode = rdmc_pkg::FG_P2P0_DB;
      default: fg_decode = rdmc_pkg::FG_0P0_DB;
    endcase
  endfunction : fg_decode

  logic [7:0] eq_straps, fg_straps;
  logic [2*NUM_CH-1:0] eq_q, eq_d, fg_q, fg_d;
  logic [NUM_CH-1:0] pd_q, pd_d, pair_en;

  assign eq_straps = {equalizer_select_ch3, equalizer_select_ch2,
                      equalizer_select_ch1, equalizer_select_ch0};
  assign fg_straps = {flat_gain_select_ch3, flat_gain_select_ch2,
                      flat_gain_select_ch1, flat_gain_select_ch0};

  // ---------------------------------------------------------------------
  // Pair enables
  // ---------------------------------------------------------------------
  // Channels 0 and 1 share the first enable, the rest the second.
  always_comb begin
    for (int i = 0; i < NUM_CH; i++) begin
      pair_en[i] = (i < 2) ? first_pair_enable : second_pair_enable;
    end
  end

  // Straps are re-decoded every cycle, so a strap change takes effect on
  // the next clock; a latched-at-reset scheme would hide board rework until reset.
  always_comb begin
    for (int i = 0; i < NUM_CH; i++) begin
      eq_d[2*i +: 2] = eq_decode(eq_straps[2*i +: 2]);
      fg_d[2*i +: 2] = fg_decode(fg_straps[2*i +: 2]);
      pd_d[i] = !pair_en[i];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      eq_q <= {NUM_CH{rdmc_pkg::EQ_RESET}};
      fg_q <= {NUM_CH{rdmc_pkg::FG_RESET}};
      pd_q <= '1;
    end else begin
      eq_q <= eq_d;
      fg_q <= fg_d;
      pd_q <= pd_d;
    end
  end

  assign eq_boost = eq_q;
  assign flat_gain = fg_q;
  assign power_down_mode = pd_q;

  // ---------------------------------------------------------------------
  // Per-channel mode machines
  // ---------------------------------------------------------------------
  for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
    rdmc_channel #(
      .INTERVAL_CYC(INTERVAL_CYC)
    ) u_channel (
      .clk(clk),
      .rst(rst),
      .pair_enable(pair_en[c]),
      .signal_active(signal_active[c]),
      .load_found(load_found[c]),
      .mode(channel_mode[2*c +: 2]),
      .detect_strobe(detect_strobe[c]),
      .in_term(in_term[2*c +: 2]),
      .out_term(out_term[2*c +: 2]),
      .detector_on(detector_on[c])
    );
  end

endmodule : rdmc_top

`default_nettype wire

// file: bench/rdmc_link_model.sv
/*
 * Link partner seen by the load probe of each channel.
 * Assumes the probe result is read in the strobe cycle or the next one.
 */
`timescale 1ns/100ps
`default_nettype none
module rdmc_link_model #(
  parameter int NUM_CH = 4
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [NUM_CH-1:0] detect_strobe,
  input wire logic [NUM_CH-1:0] load_present,
  output logic [NUM_CH-1:0] load_found
);
  logic [NUM_CH-1:0] probe_q;
  logic [NUM_CH-1:0] junk_q;
  logic [NUM_CH-1:0] probing;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      probe_q <= '0;
      junk_q <= '0;
    end else begin
      probe_q <= detect_strobe;
      junk_q <= ~junk_q;
    end
  end
  // Outside a probe the sense line toggles, so a late sample cannot pass.
  assign probing = detect_strobe | probe_q;
  assign load_found = (probing & load_present) |
    (~probing & junk_q);
endmodule : rdmc_link_model
`default_nettype wire

// file: bench/rdmc_top_asserts.sv
/*
 * Port checker bound to rdmc_top, watching channels 0, 1 and 2 and 3.
 * Assumes the bind hands on the same NUM_CH and INTERVAL_CYC.
 */
`timescale 1ns/100ps
`default_nettype none
module rdmc_top_asserts #(
  parameter int NUM_CH = 4,
  parameter int INTERVAL_CYC = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic first_pair_enable,
  input wire logic second_pair_enable,
  input wire logic [NUM_CH-1:0] signal_active,
  input wire logic [NUM_CH-1:0] load_found,
  input wire logic [1:0] equalizer_select_ch0,
  input wire logic [2*NUM_CH-1:0] channel_mode,
  input wire logic [NUM_CH-1:0] power_down_mode,
  input wire logic [NUM_CH-1:0] detect_strobe,
  input wire logic [2*NUM_CH-1:0] in_term,
  input wire logic [2*NUM_CH-1:0] out_term,
  input wire logic [2*NUM_CH-1:0] eq_boost
);
  localparam logic [1:0] PD = rdmc_pkg::RDMC_POWER_DOWN;
  localparam logic [1:0] UNP = rdmc_pkg::RDMC_UNPLUG;
  localparam logic [1:0] SLM = rdmc_pkg::RDMC_SLUMBER;
  localparam logic [1:0] ACT = rdmc_pkg::RDMC_ACTIVE;
  localparam logic [1:0] EQ_OF [4] = '{rdmc_pkg::EQ_10P9_DB,
    rdmc_pkg::EQ_6P7_DB, rdmc_pkg::EQ_8P9_DB, rdmc_pkg::EQ_13P1_DB};
  logic [1:0] m0;
  logic [1:0] m1;
  logic [31:0] gap_q;
  assign m0 = channel_mode[1:0];
  assign m1 = channel_mode[3:2];
  // Zero means no interval is timed; active and power-down clear the timer until the next strobe.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) gap_q <= '0;
    else if (m1 == ACT || m1 == PD) gap_q <= '0;
    else if (detect_strobe[1]) gap_q <= 32'h0000_0001;
    else if (gap_q != '0) gap_q <= gap_q + 32'h0000_0001;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  property p_idle;
    m0 == ACT && !signal_active[0] && first_pair_enable |=> m0 == SLM;
  endproperty
  a_idle: assert property (p_idle) else $error("no slumber");
  property p_unplug;
    detect_strobe[1] && m1 == SLM && !load_found[1] && !signal_active[1]
      && first_pair_enable |-> ##[1:2] m1 == UNP;
  endproperty
  a_unplug: assert property (p_unplug) else $error("no unplug");
  property p_replug;
    detect_strobe[1] && m1 == UNP && load_found[1] && first_pair_enable
      |-> ##[1:2] m1 == SLM;
  endproperty
  a_replug: assert property (p_replug) else $error("no replug");
  property p_gap; detect_strobe[1] && gap_q != '0 |-> gap_q == INTERVAL_CYC;
  endproperty
  a_gap: assert property (p_gap) else $error("bad probe gap");
  property p_term;
    in_term[1:0] == (m0 == PD ? rdmc_pkg::IN_TERM_WEAK_GND : m0 == UNP ?
      rdmc_pkg::IN_TERM_HIGHZ : rdmc_pkg::IN_TERM_50_OHM) &&
      out_term[1:0] == (m0 == PD ? rdmc_pkg::OUT_TERM_HIGHZ : m0 == ACT ?
      rdmc_pkg::OUT_TERM_50_OHM : rdmc_pkg::OUT_TERM_WEAK_VDD);
  endproperty
  a_term: assert property (p_term) else $error("bad termination");
  property p_eq;
    !$past(rst) |-> eq_boost[1:0] == $past(EQ_OF[equalizer_select_ch0]);
  endproperty
  a_eq: assert property (p_eq) else $error("bad eq decode");
  property p_pd; !second_pair_enable |=> channel_mode[7:4] == {PD, PD} &&
    power_down_mode[3:2] == 2'h3; endproperty
  a_pd: assert property (p_pd) else $error("pair not down");
  property p_wake; m0 == SLM && signal_active[0] && first_pair_enable |=>
    m0 == ACT && out_term[1:0] == rdmc_pkg::OUT_TERM_50_OHM; endproperty
  a_wake: assert property (p_wake) else $error("no wake");
  c_unplug: cover property (m1 == UNP);
  c_split: cover property (m0 == ACT && m1 == SLM);
  c_pd: cover property (power_down_mode[2]);
endmodule : rdmc_top_asserts
bind rdmc_top rdmc_top_asserts #(.NUM_CH(NUM_CH),
  .INTERVAL_CYC(INTERVAL_CYC)) chk_u (.*);
`default_nettype wire

// file: bench/rdmc_top_bench.sv
/*
 * Bench for rdmc_top: straps, activity, load probes and pair enables.
 * Assumes the probe interval is shortened to IV cycles.
 */
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin mismatches++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e); end end
module rdmc_top_bench;
  localparam int IV = 8;
  localparam logic [1:0] SLM = rdmc_pkg::RDMC_SLUMBER;
  localparam logic [1:0] ACT = rdmc_pkg::RDMC_ACTIVE;
  localparam logic [1:0] UNP = rdmc_pkg::RDMC_UNPLUG;
  localparam logic [1:0] PD = rdmc_pkg::RDMC_POWER_DOWN;
  localparam logic [1:0] EQ_OF [4] = '{rdmc_pkg::EQ_10P9_DB,
    rdmc_pkg::EQ_6P7_DB, rdmc_pkg::EQ_8P9_DB, rdmc_pkg::EQ_13P1_DB};
  localparam logic [1:0] FG_OF [4] = '{rdmc_pkg::FG_M3P0_DB,
    rdmc_pkg::FG_M1P5_DB, rdmc_pkg::FG_0P0_DB, rdmc_pkg::FG_P2P0_DB};
  localparam logic [3:0] T_SLM = {rdmc_pkg::IN_TERM_50_OHM,
    rdmc_pkg::OUT_TERM_WEAK_VDD};
  localparam logic [3:0] T_ACT = {rdmc_pkg::IN_TERM_50_OHM,
    rdmc_pkg::OUT_TERM_50_OHM};
  localparam logic [3:0] T_UNP = {rdmc_pkg::IN_TERM_HIGHZ,
    rdmc_pkg::OUT_TERM_WEAK_VDD};
  localparam logic [3:0] T_PD = {rdmc_pkg::IN_TERM_WEAK_GND,
    rdmc_pkg::OUT_TERM_HIGHZ};
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic first_pair_enable = 1'b1;
  logic second_pair_enable = 1'b1;
  logic [3:0] signal_active = 4'h0;
  logic [3:0] load_present = 4'hf;
  logic [1:0] equalizer_select_ch0, equalizer_select_ch1;
  logic [1:0] equalizer_select_ch2, equalizer_select_ch3;
  logic [1:0] flat_gain_select_ch0, flat_gain_select_ch1;
  logic [1:0] flat_gain_select_ch2, flat_gain_select_ch3;
  logic [3:0] load_found, power_down_mode, detect_strobe, detector_on;
  logic [7:0] channel_mode, in_term, out_term, eq_boost, flat_gain;
  int mismatches = 0;
  int cmp_count = 0;
  rdmc_top #(.INTERVAL_CYC(IV)) dut_u (.*);
  rdmc_link_model link_u (.clk(clk), .rst(rst), .detect_strobe(detect_strobe),
    .load_present(load_present), .load_found(load_found));
  always #2 clk = ~clk;
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  // Codes rotate across channels so that a swapped channel shows up.
  task automatic straps(input logic [1:0] k);
    {equalizer_select_ch3, equalizer_select_ch2, equalizer_select_ch1,
      equalizer_select_ch0} <= {k + 2'h3, k + 2'h2, k + 2'h1, k};
    {flat_gain_select_ch3, flat_gain_select_ch2, flat_gain_select_ch1,
      flat_gain_select_ch0} <= {k, k + 2'h3, k + 2'h2, k + 2'h1};
  endtask : straps
  task automatic wstb(input int c);
    int n;
    n = 0;
    do begin
      cyc(1);
      n++;
    end while (detect_strobe[c] !== 1'b1 && n < 4 * IV);
    `CHK(detect_strobe[c], 1'b1)
    cyc(3);
  endtask : wstb
  task automatic summarize();
    if (mismatches == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : summarize
  initial begin
    straps(2'h2);
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    cyc(3);
    `CHK(channel_mode, {4{SLM}})
    `CHK({in_term[1:0], out_term[1:0]}, T_SLM)
    `CHK(detector_on, 4'hf)
    for (int k = 0; k < 4; k++) begin
      @(posedge clk);
      straps(2'(k));
      cyc(2);
      for (int c = 0; c < 4; c++) begin
        `CHK(eq_boost[2*c+:2], EQ_OF[2'(k + c)])
        `CHK(flat_gain[2*c+:2], FG_OF[2'(k + c + 1)])
      end
    end
    @(posedge clk);
    signal_active <= 4'h1;
    cyc(2);
    `CHK(channel_mode[3:0], {SLM, ACT})
    `CHK({in_term[1:0], out_term[1:0]}, T_ACT)
    @(posedge clk);
    signal_active <= 4'h0;
    cyc(2);
    `CHK({channel_mode[1:0], detector_on[0]}, {SLM, 1'b1})
    wstb(1);
    @(posedge clk);
    load_present[1] <= 1'b0;
    wstb(1);
    `CHK(channel_mode[3:2], UNP)
    `CHK({in_term[3:2], out_term[3:2]}, T_UNP)
    @(posedge clk);
    load_present[1] <= 1'b1;
    wstb(1);
    `CHK(channel_mode[3:2], SLM)
    @(posedge clk);
    second_pair_enable <= 1'b0;
    signal_active <= 4'h4;
    cyc(2);
    `CHK({channel_mode[7:4], power_down_mode}, {PD, PD, 4'hc})
    `CHK({in_term[5:4], out_term[5:4], detector_on[2]}, {T_PD, 1'b0})
    @(posedge clk);
    second_pair_enable <= 1'b1;
    cyc(3);
    `CHK(channel_mode[7:4], {SLM, ACT})
    `CHK(power_down_mode, 4'h0)
    summarize();
  end
  initial begin
    repeat (1000) @(posedge clk);
    mismatches++;
    summarize();
  end
endmodule : rdmc_top_bench
`default_nettype wire
